// *** qec_pkg.sv ***
// shared constants for the quadrature event counter
package qec_pkg;
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_MIN = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam int SYNC_STAGES = 3;
    // reload_or_freerun_select encoding
    localparam logic SEL_RELOAD = 1'b0;
    localparam logic SEL_FREERUN = 1'b1;
    // quad_edge_processing_select encoding
    localparam logic SEL_NORMAL = 1'b0;
    localparam logic SEL_X4 = 1'b1;
endpackage

// *** qec_step_if.sv ***
// count step pulses passed from the phase decoder to the counter
`timescale 1ns/10ps
interface qec_step_if;
    logic step_up;
    logic step_down;
    modport decoder (output step_up, output step_down);
    modport counter (input step_up, input step_down);
endinterface

// *** qec_phase_decoder.sv ***
// two-phase pin synchroniser and up/down step decoder
`timescale 1ns/10ps
module qec_phase_decoder
    import qec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic phase_a_input_pin,
    input wire logic phase_b_input_pin,
    input wire logic quad_edge_processing_select,
    qec_step_if.decoder step
);
    typedef struct packed {
        logic [SYNC_STAGES-1:0] a_sync;
        logic [SYNC_STAGES-1:0] b_sync;
        logic a_filt;
        logic b_filt;
        logic [1:0] warm;
        logic up;
        logic down;
    } dec_state_t;

    dec_state_t st_q;
    dec_state_t st_d;
    logic a_new;
    logic b_new;
    logic a_chg;
    logic b_chg;
    logic warm_done;

    // shift pins in, accept a level once stages two and three agree
    always_comb
    begin
        st_d = st_q;
        st_d.a_sync = {st_q.a_sync[SYNC_STAGES-2:0],
                       phase_a_input_pin};
        st_d.b_sync = {st_q.b_sync[SYNC_STAGES-2:0],
                       phase_b_input_pin};
        a_new = st_q.a_filt;
        b_new = st_q.b_filt;
        if (st_q.a_sync[1] == st_q.a_sync[2])
        begin
            a_new = st_q.a_sync[2];
        end
        if (st_q.b_sync[1] == st_q.b_sync[2])
        begin
            b_new = st_q.b_sync[2];
        end
        // after reset, follow the pins without stepping: no false edge
        warm_done = st_q.warm == 2'(SYNC_STAGES);
        if (!warm_done)
        begin
            st_d.warm = st_q.warm + 2'h1;
            a_new = st_q.a_sync[1];
            b_new = st_q.b_sync[1];
        end
        a_chg = warm_done && (a_new != st_q.a_filt);
        b_chg = warm_done && (b_new != st_q.b_filt);
        st_d.a_filt = a_new;
        st_d.b_filt = b_new;
        st_d.up = 1'b0;
        st_d.down = 1'b0;
        if (quad_edge_processing_select == SEL_X4)
        begin
            // one pin moved: direction from old a against new b
            if (a_chg ^ b_chg)
            begin
                st_d.up = ~(st_q.a_filt ^ b_new);
                st_d.down = st_q.a_filt ^ b_new;
            end
        end
        else
        begin
            // normal: only b edges while a is high
            if (b_chg && !a_chg && st_q.a_filt)
            begin
                st_d.up = b_new;
                st_d.down = ~b_new;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign step.step_up = st_q.up;
    assign step.step_down = st_q.down;
endmodule

// *** quadrature_event_counter.sv ***
// quadrature event counter channel top
//
// Summary of operation
// - Counting begins only after the channel start bit is set to one.
// - Counting stops when the channel start bit is cleared to zero.
// - An interrupt pulse is raised on each overflow up or underflow down.
// - Both channel pins serve as inputs for the two phases.
// - The count output always shows the live counter value.
// - While idle a write loads both the reload register and the counter.
// - After the first count while active a write loads only the reload.
// - In x4 mode, b rising with a high gives an up count on every edge.
// - In x4 mode, b falling with a high gives a down count on every edge.
// - Reload type reloads on wrap, free-run type wraps without reload.
// - One select bit picks normal or x4, another picks reload or free-run.
`timescale 1ns/10ps
module quadrature_event_counter
    import qec_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic CHANNEL_COUNT_START_BIT,
    input wire logic RELOAD_OR_FREERUN_SELECT,
    input wire logic QUAD_EDGE_PROCESSING_SELECT,
    input wire logic PHASE_A_INPUT_PIN_I,
    output logic PHASE_A_INPUT_PIN_O,
    output logic PHASE_A_INPUT_PIN_OE,
    input wire logic PHASE_B_INPUT_PIN,
    input wire logic COUNT_WR_STB,
    input wire logic [CNT_W-1:0] COUNT_WR_DATA,
    output logic [CNT_W-1:0] CHANNEL_COUNT_REGISTER,
    output logic COUNTING,
    output logic IRQ
);
    // run phase of the channel, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_ACTIVE = 3'b100
    } run_phase_t;

    // every register of the channel
    typedef struct packed {
        run_phase_t phase;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] reload;
        logic irq;
        logic counting;
        logic pin_o;
        logic pin_oe;
    } cnt_state_t;

    // state and its next value
    cnt_state_t st_q;
    cnt_state_t st_d;

    // decisions of the current cycle
    logic run;
    logic take_up;
    logic take_down;
    logic at_top;
    logic at_bottom;
    logic free_run;
    logic locked;

    // step pulses from the decoder
    qec_step_if step_bus ();

    // edge decoding of the two phase pins
    qec_phase_decoder u_decoder (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .phase_a_input_pin(PHASE_A_INPUT_PIN_I),
        .phase_b_input_pin(PHASE_B_INPUT_PIN),
        .quad_edge_processing_select(QUAD_EDGE_PROCESSING_SELECT),
        .step(step_bus.decoder)
    );

    // next state of the whole channel
    always_comb
    begin
        st_d = st_q;
        // interrupt is a one-cycle pulse
        st_d.irq = 1'b0;

        // start bit gates every count step
        run = CHANNEL_COUNT_START_BIT;
        take_up = run && step_bus.step_up;
        take_down = run && step_bus.step_down && !step_bus.step_up;

        // ends of the count range
        at_top = st_q.count == CNT_MAX;
        at_bottom = st_q.count == CNT_MIN;

        // count type select
        free_run = RELOAD_OR_FREERUN_SELECT == SEL_FREERUN;

        // writes reach only the reload once a step was taken
        locked = run && (st_q.phase == ST_ACTIVE);

        // run phase: stopped, started, first step seen
        unique case (st_q.phase)
            ST_IDLE:
            begin
                if (take_up || take_down)
                begin
                    st_d.phase = ST_ACTIVE;
                end
                else if (run)
                begin
                    st_d.phase = ST_ARMED;
                end
            end

            ST_ARMED:
            begin
                if (!run)
                begin
                    st_d.phase = ST_IDLE;
                end
                else if (take_up || take_down)
                begin
                    st_d.phase = ST_ACTIVE;
                end
            end

            ST_ACTIVE:
            begin
                if (!run)
                begin
                    st_d.phase = ST_IDLE;
                end
            end

            default:
            begin
                st_d.phase = ST_IDLE; // illegal code recovers
            end
        endcase

        // software write of the count register
        if (COUNT_WR_STB)
        begin
            st_d.reload = COUNT_WR_DATA;
            if (!locked)
            begin
                st_d.count = COUNT_WR_DATA;
            end
        end

        // step up; a step wins over a write in the same cycle
        if (take_up)
        begin
            if (at_top)
            begin
                st_d.irq = 1'b1;
                // free-run wraps, reload type restarts from the reload
                if (free_run)
                begin
                    st_d.count = CNT_MIN;
                end
                else
                begin
                    st_d.count = st_d.reload;
                end
            end
            else
            begin
                st_d.count = st_q.count + 16'h0001;
            end
        end

        // step down, same wrap handling at the bottom
        if (take_down)
        begin
            if (at_bottom)
            begin
                st_d.irq = 1'b1;
                // free-run wraps, reload type restarts from the reload
                if (free_run)
                begin
                    st_d.count = CNT_MAX;
                end
                else
                begin
                    st_d.count = st_d.reload;
                end
            end
            else
            begin
                st_d.count = st_q.count - 16'h0001;
            end
        end

        // phase A pin stays an input, flag follows the phase
        st_d.pin_o = 1'b0;
        st_d.pin_oe = 1'b0;
        st_d.counting = st_q.phase == ST_ACTIVE;
    end

    // state register, the only clocked process
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            st_q <= '{phase: ST_IDLE, count: CNT_RESET,
                      reload: RELOAD_RESET, irq: 1'b0,
                      counting: 1'b0, pin_o: 1'b0, pin_oe: 1'b0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // every output straight from the state register
    assign CHANNEL_COUNT_REGISTER = st_q.count;
    assign IRQ = st_q.irq;
    assign COUNTING = st_q.counting;
    assign PHASE_A_INPUT_PIN_O = st_q.pin_o;
    assign PHASE_A_INPUT_PIN_OE = st_q.pin_oe;
endmodule

// *** qec_monitor.sv ***
// port checker for the quadrature event counter
`timescale 1ns/10ps
module qec_monitor
    import qec_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic CHANNEL_COUNT_START_BIT,
    input wire logic RELOAD_OR_FREERUN_SELECT,
    input wire logic PHASE_A_INPUT_PIN_OE,
    input wire logic COUNT_WR_STB,
    input wire logic [CNT_W-1:0] COUNT_WR_DATA,
    input wire logic [CNT_W-1:0] CHANNEL_COUNT_REGISTER,
    input wire logic COUNTING,
    input wire logic IRQ
);
    // short alias of the live count
    wire [15:0] c = CHANNEL_COUNT_REGISTER;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    sequence s_idle_wr;
        COUNT_WR_STB && !CHANNEL_COUNT_START_BIT;
    endsequence
    chk_pin_input: assert property (
        PHASE_A_INPUT_PIN_OE == 1'b0) else $error("pin driven");
    chk_stop_hold: assert property (
        s_idle_wr or !CHANNEL_COUNT_START_BIT && !COUNT_WR_STB |=>
        $stable(c) || $past(COUNT_WR_STB)) else $error("count moved");
    chk_idle_load: assert property (
        s_idle_wr |=> c == $past(COUNT_WR_DATA)) else $error("no load");
    chk_irq_single: assert property (
        IRQ |=> !IRQ) else $error("irq long");
    chk_irq_wrap: assert property (
        IRQ |-> $past(c) == CNT_MAX || $past(c) == CNT_MIN)
        else $error("irq no wrap");
    chk_free_wrap: assert property (
        IRQ && RELOAD_OR_FREERUN_SELECT == SEL_FREERUN |-> c == ~$past(c))
        else $error("bad wrap");
    chk_unit_step: assert property (
        !$past(COUNT_WR_STB) && !IRQ |->
        c - $past(c) inside {16'h0000, 16'h0001, 16'hFFFF})
        else $error("big step");
    chk_start_gate: assert property (
        $rose(COUNTING) |-> $past(CHANNEL_COUNT_START_BIT, 2))
        else $error("count unstarted");
endmodule

// *** qec_encoder_model.sv ***
// two-phase source, one pin change per request
`timescale 1ns/10ps
module qec_encoder_model (
    input wire logic clk,
    input wire logic up,
    input wire logic dn,
    output logic a,
    output logic b
);
    logic [1:0] s_q = 2'h0;
    // walk 10,11,01,00 for up, reverse for down
    always @(posedge clk)
        s_q <= s_q + {dn, up | dn};
    assign a = ~s_q[1];
    assign b = s_q[1] ^ s_q[0];
endmodule

// *** quadrature_event_counter_test.sv ***
// self-checking bench for the quadrature event counter
`timescale 1ns/10ps
module quadrature_event_counter_test;
    import qec_pkg::*;
    logic clk = 0, rst_n = 0, go = 0, fr = SEL_RELOAD, x4 = SEL_X4;
    logic up = 0, dn = 0, wr = 0, a, b, a_o, a_oe, cnting, irq;
    logic [15:0] wd = 16'h0000, cnt;
    int fails = 0, n_tests = 0, irqs = 0;
    initial forever #5 clk = ~clk;
    qec_encoder_model i_qec_encoder_model (.clk(clk), .up(up), .dn(dn),
        .a(a), .b(b));
    quadrature_event_counter i_quadrature_event_counter (.CLK_SYS(clk),
        .RESET_N(rst_n), .CHANNEL_COUNT_START_BIT(go),
        .RELOAD_OR_FREERUN_SELECT(fr), .QUAD_EDGE_PROCESSING_SELECT(x4),
        .PHASE_A_INPUT_PIN_I(a), .PHASE_A_INPUT_PIN_O(a_o),
        .PHASE_A_INPUT_PIN_OE(a_oe), .PHASE_B_INPUT_PIN(b),
        .COUNT_WR_STB(wr), .COUNT_WR_DATA(wd),
        .CHANNEL_COUNT_REGISTER(cnt), .COUNTING(cnting), .IRQ(irq));
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // wait cycles at falling edges, counting irq pulses
    task automatic wait_n(int n);
        repeat (n)
        begin
            @(negedge clk);
            irqs += (irq === 1'b1);
        end
    endtask
    task automatic step(int n, logic u);
        repeat (n)
        begin
            up <= u;
            dn <= !u;
            wait_n(1);
            up <= 0;
            dn <= 0;
            wait_n(6);
        end
    endtask
    task automatic write(logic [15:0] d);
        wr <= 1;
        wd <= d;
        wait_n(1);
        wr <= 0;
        wait_n(1);
    endtask
    task automatic sc_idle();
        write(16'h1234);
        chk("idle wr", 16'h1234, cnt);
        step(3, 1);
        chk("idle", 16'h1234, cnt);
        chk("pin", 16'h0000, {14'h0, a_o, a_oe});
        chk("flag", 16'h0000, {15'h0, cnting});
    endtask
    task automatic sc_count();
        go <= 1;
        step(3, 1);
        chk("up", 16'h1237, cnt);
        chk("flag", 16'h0001, {15'h0, cnting});
        step(2, 0);
        chk("down", 16'h1235, cnt);
        write(16'h0005);
        chk("busy wr", 16'h1235, cnt);
    endtask
    task automatic sc_reload();
        go <= 0;
        wait_n(2);
        chk("flag", 16'h0000, {15'h0, cnting});
        write(16'hFFFE);
        go <= 1;
        step(1, 1);
        write(16'h0005);
        chk("no load", 16'hFFFF, cnt);
        irqs = 0;
        step(1, 1);
        chk("reload", 16'h0005, cnt);
        chk("irq", 16'h0001, 16'(irqs));
    endtask
    task automatic sc_free();
        go <= 0;
        fr <= SEL_FREERUN;
        wait_n(2);
        write(16'h0000);
        go <= 1;
        step(1, 0);
        chk("under", 16'hFFFF, cnt);
        step(1, 1);
        chk("over", 16'h0000, cnt);
        chk("irqs", 16'h0003, 16'(irqs));
        x4 <= SEL_NORMAL;
        step(4, 1);
        chk("normal", 16'h0001, cnt);
        step(4, 0);
        chk("normal dn", 16'h0000, cnt);
        go <= 0;
        step(4, 1);
        chk("stop", 16'h0000, cnt);
    endtask
    task automatic close_out();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(negedge clk);
        rst_n <= 1;
        wait_n(2);
        sc_idle();
        sc_count();
        sc_reload();
        sc_free();
        close_out();
    end
endmodule
bind quadrature_event_counter qec_monitor i_qec_monitor (.CLK_SYS,
    .RESET_N, .CHANNEL_COUNT_START_BIT, .RELOAD_OR_FREERUN_SELECT,
    .PHASE_A_INPUT_PIN_OE, .COUNT_WR_STB, .COUNT_WR_DATA,
    .CHANNEL_COUNT_REGISTER, .COUNTING, .IRQ);
